// File: design/ltf_pkg.sv
// Shared constants and types for the time code framer
package ltf_pkg;

    // Clock and line rate
    localparam int CLK_HZ         = 40_000_000;
    localparam int WORD_BITS      = 80;
    localparam int HALVES_PER_BIT = 2;
    localparam int FPS_24         = 24;
    localparam int FPS_25         = 25;
    localparam int FPS_30         = 30;
    localparam int HALF_DIV_24    = CLK_HZ / (FPS_24 * WORD_BITS * HALVES_PER_BIT);
    localparam int HALF_DIV_25    = CLK_HZ / (FPS_25 * WORD_BITS * HALVES_PER_BIT);
    localparam int HALF_DIV_30    = CLK_HZ / (FPS_30 * WORD_BITS * HALVES_PER_BIT);
    localparam int DIV_W          = 14;

    // Word layout
    localparam int              GROUP_W   = 4;
    localparam int              HALF_GRP  = 8;
    localparam int              SYNC_POS  = 64;
    localparam int              SYNC_W    = 16;
    localparam int              ONES_LO   = 2;
    localparam int              ONES_LEN  = 12;
    localparam logic [15:0]     SYNC_WORD = 16'hbffc;
    localparam logic [6:0]      LAST_BIT  = 7'h4f;
    localparam logic [6:0]      BIT_ONE   = 7'h01;
    localparam logic [3:0]      SKIP_FLAG = 4'h4;

    // Counting limits, packed BCD
    localparam logic [3:0] DIGIT_MAX   = 4'h9;
    localparam logic [3:0] DIGIT_ONE   = 4'h1;
    localparam logic [3:0] DROP_FIRST  = 4'h2;
    localparam logic [7:0] FRM_LAST_24 = 8'h23;
    localparam logic [7:0] FRM_LAST_25 = 8'h24;
    localparam logic [7:0] FRM_LAST_30 = 8'h29;
    localparam logic [7:0] SEC_LAST    = 8'h59;
    localparam logic [7:0] MIN_LAST    = 8'h59;
    localparam logic [7:0] HR_LAST     = 8'h23;

    typedef enum logic [1:0] {FMT_24, FMT_25, FMT_30, FMT_30_SKIP} ltf_fmt_t;

    typedef struct packed {
        logic [3:0] hr_t;
        logic [3:0] hr_u;
        logic [3:0] min_t;
        logic [3:0] min_u;
        logic [3:0] sec_t;
        logic [3:0] sec_u;
        logic [3:0] frm_t;
        logic [3:0] frm_u;
    } ltf_time_t;

    // Highest frame number for a format
    function automatic logic [7:0] frm_last(input ltf_fmt_t f);
        unique case (f)
            FMT_24:      return FRM_LAST_24;
            FMT_25:      return FRM_LAST_25;
            FMT_30:      return FRM_LAST_30;
            FMT_30_SKIP: return FRM_LAST_30;
        endcase
    endfunction

endpackage

// File: design/ltf_time_counter.sv
// Time address counter with 24, 25, 30 and skip-count formats
`timescale 1ns/1ps
module ltf_time_counter
(
    input  wire logic              clk_sys_in,
    input  wire logic              rst_n_in,
    input  wire ltf_pkg::ltf_fmt_t fmt_in,
    input  wire logic              load_in,
    input  wire ltf_pkg::ltf_time_t preset_in,
    input  wire logic              step_in,
    output ltf_pkg::ltf_time_t     time_out
);

    ltf_pkg::ltf_time_t cur;
    ltf_pkg::ltf_time_t next_cur;
    logic               f_wrap;
    logic               s_wrap;
    logic               m_wrap;

    // BCD pair step with wrap to zero after last
    function automatic logic [7:0] inc_pair(input logic [3:0] t, input logic [3:0] u,
                                            input logic [7:0] last);
        if ({t, u} == last)
            return '0;
        else if (u == ltf_pkg::DIGIT_MAX)
            return {t + ltf_pkg::DIGIT_ONE, 4'h0};
        else
            return {t, u + ltf_pkg::DIGIT_ONE};
    endfunction

    always_comb
    begin
        next_cur = cur;
        f_wrap   = {cur.frm_t, cur.frm_u} == ltf_pkg::frm_last(fmt_in);
        s_wrap   = {cur.sec_t, cur.sec_u} == ltf_pkg::SEC_LAST;
        m_wrap   = {cur.min_t, cur.min_u} == ltf_pkg::MIN_LAST;
        if (load_in)
            next_cur = preset_in;
        else if (step_in)
        begin
            {next_cur.frm_t, next_cur.frm_u} =
                inc_pair(cur.frm_t, cur.frm_u, ltf_pkg::frm_last(fmt_in));
            if (f_wrap)
                {next_cur.sec_t, next_cur.sec_u} =
                    inc_pair(cur.sec_t, cur.sec_u, ltf_pkg::SEC_LAST);
            if (f_wrap && s_wrap)
                {next_cur.min_t, next_cur.min_u} =
                    inc_pair(cur.min_t, cur.min_u, ltf_pkg::MIN_LAST);
            if (f_wrap && s_wrap && m_wrap)
                {next_cur.hr_t, next_cur.hr_u} =
                    inc_pair(cur.hr_t, cur.hr_u, ltf_pkg::HR_LAST);
            // Skip frames 0 and 1 except every tenth minute
            if (fmt_in == ltf_pkg::FMT_30_SKIP && f_wrap && s_wrap && next_cur.min_u != '0)
                next_cur.frm_u = ltf_pkg::DROP_FIRST;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            cur <= '0;
        else
            cur <= next_cur;
    end

    assign time_out = cur;

    ////////////////////////////////////////////////////////////////////////////
    property p_sec_carry;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        step_in && !load_in && f_wrap && s_wrap
        |=> {cur.sec_t, cur.sec_u} == 8'h00 && cur.min_u != $past(cur.min_u);
    endproperty
    a_sec_carry: assert property (p_sec_carry) else $error("seconds did not carry");

    property p_frm_wrap;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        step_in && !load_in && f_wrap
        |=> cur.frm_t == 4'h0 && cur.sec_u != $past(cur.sec_u);
    endproperty
    a_frm_wrap: assert property (p_frm_wrap) else $error("frame did not wrap");

    property p_drop;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        step_in && !load_in && f_wrap && s_wrap && fmt_in == ltf_pkg::FMT_30_SKIP
        && cur.min_u != 4'h9 |=> cur.frm_u == 4'h2;
    endproperty
    a_drop: assert property (p_drop) else $error("frames 0 and 1 not skipped");

    property p_no_drop;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        step_in && !load_in && f_wrap && s_wrap
        && (fmt_in != ltf_pkg::FMT_30_SKIP || cur.min_u == 4'h9) |=> cur.frm_u == 4'h0;
    endproperty
    a_no_drop: assert property (p_no_drop) else $error("frame skipped wrongly");

endmodule

// File: design/ltf_biphase_enc.sv
// Biphase line encoder driven by half-cell ticks
`timescale 1ns/1ps
module ltf_biphase_enc
(
    input  wire logic clk_sys_in,
    input  wire logic rst_n_in,
    input  wire logic half_tick_in,
    input  wire logic cell_start_in,
    input  wire logic bit_in,
    output logic      line_out
);

    logic line;
    logic next_line;

    always_comb
    begin
        next_line = line;
        if (half_tick_in && cell_start_in)
            next_line = !line;
        else if (half_tick_in && bit_in)
            next_line = !line;
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            line <= 1'b0;
        else
            line <= next_line;
    end

    assign line_out = line;

    ////////////////////////////////////////////////////////////////////////////
    property p_edge;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        half_tick_in && cell_start_in |=> line_out != $past(line_out);
    endproperty
    a_edge: assert property (p_edge) else $error("no cell boundary transition");

    property p_mid;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        half_tick_in && !cell_start_in |=> (line_out != $past(line_out)) == $past(bit_in);
    endproperty
    a_mid: assert property (p_mid) else $error("mid cell level wrong for bit");

    property p_hold;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        !half_tick_in |=> $stable(line_out);
    endproperty
    a_hold: assert property (p_hold) else $error("line moved between ticks");

endmodule

// File: design/ltf_framer.sv
// Longitudinal time code framer: word assembly, bit timing, line output
`timescale 1ns/1ps
module ltf_framer
#(
    parameter int HALF_DIV_24 = ltf_pkg::HALF_DIV_24,
    parameter int HALF_DIV_25 = ltf_pkg::HALF_DIV_25,
    parameter int HALF_DIV_30 = ltf_pkg::HALF_DIV_30
)
(
    input  wire logic               clk_sys_in,
    input  wire logic               rst_n_in,
    input  wire logic               run_in,
    input  wire ltf_pkg::ltf_fmt_t  fmt_in,
    input  wire logic               load_in,
    input  wire ltf_pkg::ltf_time_t preset_in,
    input  wire logic [31:0]        user_bits_in,
    output logic                    longitudinal_code_out,
    output ltf_pkg::ltf_time_t      time_out,
    output logic                    word_start_out,
    output logic                    running_out
);

    typedef enum logic {ST_IDLE, ST_RUN} ltf_state_t;

    ltf_state_t                    state;
    ltf_state_t                    next_state;
    logic [ltf_pkg::DIV_W-1:0]     div_cnt;
    logic [ltf_pkg::DIV_W-1:0]     next_div_cnt;
    logic [ltf_pkg::DIV_W-1:0]     div_last;
    logic                          phase;
    logic                          next_phase;
    logic [6:0]                    bit_idx;
    logic [6:0]                    next_bit_idx;
    logic [79:0]                   word;
    logic [79:0]                   next_word;
    ltf_pkg::ltf_time_t            word_time;
    ltf_pkg::ltf_time_t            next_word_time;
    logic                          word_start;
    logic                          next_word_start;
    ltf_pkg::ltf_time_t            cnt_time;
    logic                          half_tick;
    logic                          cell_start;
    logic                          cell_end;
    logic                          word_end;
    logic                          step;

    ////////////////////////////////////////////////////////////////////////////
    // Word packing: time nibble and user nibble alternate, sync on top
    function automatic logic [79:0] pack_word(input ltf_pkg::ltf_time_t t,
                                              input logic [31:0] ub,
                                              input logic skip);
        logic [31:0] tv;
        logic [79:0] w;
        tv = t;
        if (skip)
            tv[ltf_pkg::GROUP_W +: ltf_pkg::GROUP_W] =
                t.frm_t | ltf_pkg::SKIP_FLAG;
        w = '0;
        for (int i = 0; i < ltf_pkg::HALF_GRP; i++)
        begin
            w[2*i*ltf_pkg::GROUP_W +: ltf_pkg::GROUP_W] =
                tv[i*ltf_pkg::GROUP_W +: ltf_pkg::GROUP_W];
            w[(2*i+1)*ltf_pkg::GROUP_W +: ltf_pkg::GROUP_W] =
                ub[i*ltf_pkg::GROUP_W +: ltf_pkg::GROUP_W];
        end
        w[ltf_pkg::SYNC_POS +: ltf_pkg::SYNC_W] = ltf_pkg::SYNC_WORD;
        return w;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Half-cell divider, rate follows format
    always_comb
    begin
        unique case (fmt_in)
            ltf_pkg::FMT_24:      div_last = ltf_pkg::DIV_W'(HALF_DIV_24 - 1);
            ltf_pkg::FMT_25:      div_last = ltf_pkg::DIV_W'(HALF_DIV_25 - 1);
            ltf_pkg::FMT_30:      div_last = ltf_pkg::DIV_W'(HALF_DIV_30 - 1);
            ltf_pkg::FMT_30_SKIP: div_last = ltf_pkg::DIV_W'(HALF_DIV_30 - 1);
        endcase
    end

    assign half_tick  = (state == ST_RUN) && (div_cnt >= div_last);
    assign cell_start = half_tick && !phase;
    assign cell_end   = half_tick && phase;
    assign word_end   = cell_end && (bit_idx == ltf_pkg::LAST_BIT);
    // Advance time during the last cell so the next word sees it
    assign step       = cell_start && (bit_idx == ltf_pkg::LAST_BIT);

    ////////////////////////////////////////////////////////////////////////////
    // Sequencing of cells and words
    always_comb
    begin
        next_state      = state;
        next_div_cnt    = div_cnt;
        next_phase      = phase;
        next_bit_idx    = bit_idx;
        next_word       = word;
        next_word_time  = word_time;
        next_word_start = 1'b0;
        unique case (state)
            ST_IDLE:
            begin
                if (run_in)
                begin
                    next_state      = ST_RUN;
                    next_div_cnt    = '0;
                    next_phase      = 1'b0;
                    next_bit_idx    = '0;
                    next_word       = pack_word(cnt_time, user_bits_in,
                                                fmt_in == ltf_pkg::FMT_30_SKIP);
                    next_word_time  = cnt_time;
                    next_word_start = 1'b1;
                end
            end
            ST_RUN:
            begin
                next_div_cnt = half_tick ? '0 : div_cnt + ltf_pkg::DIV_W'(1);
                if (half_tick)
                    next_phase = !phase;
                if (cell_end)
                    next_bit_idx = bit_idx + ltf_pkg::BIT_ONE;
                if (word_end)
                begin
                    next_bit_idx = '0;
                    if (run_in)
                    begin
                        // Next word follows with no gap
                        next_word       = pack_word(cnt_time, user_bits_in,
                                                    fmt_in == ltf_pkg::FMT_30_SKIP);
                        next_word_time  = cnt_time;
                        next_word_start = 1'b1;
                    end
                    else
                        next_state = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state      <= ST_IDLE;
            div_cnt    <= '0;
            phase      <= 1'b0;
            bit_idx    <= '0;
            word       <= '0;
            word_time  <= '0;
            word_start <= 1'b0;
        end
        else
        begin
            state      <= next_state;
            div_cnt    <= next_div_cnt;
            phase      <= next_phase;
            bit_idx    <= next_bit_idx;
            word       <= next_word;
            word_time  <= next_word_time;
            word_start <= next_word_start;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Submodules
    ltf_time_counter u_counter
    (
        .clk_sys_in (clk_sys_in),
        .rst_n_in   (rst_n_in),
        .fmt_in     (fmt_in),
        .load_in    (load_in),
        .preset_in  (preset_in),
        .step_in    (step),
        .time_out   (cnt_time)
    );

    ltf_biphase_enc u_enc
    (
        .clk_sys_in    (clk_sys_in),
        .rst_n_in      (rst_n_in),
        .half_tick_in  (half_tick),
        .cell_start_in (cell_start),
        .bit_in        (word[bit_idx]),
        .line_out      (longitudinal_code_out)
    );

    assign time_out       = word_time;
    assign word_start_out = word_start;
    assign running_out    = (state == ST_RUN);

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    logic [6:0] cells_seen;
    logic [6:0] next_cells_seen;

    always_comb
    begin
        next_cells_seen = cells_seen;
        if (word_start)
            next_cells_seen = '0;
        else if (cell_end)
            next_cells_seen = cells_seen + ltf_pkg::BIT_ONE;
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            cells_seen <= '0;
        else
            cells_seen <= next_cells_seen;
    end

    property p_word_len;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        word_end |-> cells_seen == ltf_pkg::LAST_BIT;
    endproperty
    a_word_len: assert property (p_word_len) else $error("word not 80 cells");

    sequence s_word_end_run;
        word_end && run_in;
    endsequence

    sequence s_next_word;
        word_start_out && running_out && bit_idx == 7'h00 && !phase;
    endsequence

    property p_back2back;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        s_word_end_run |=> s_next_word;
    endproperty
    a_back2back: assert property (p_back2back) else $error("gap between words");

    property p_sync;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        running_out |-> word[79:64] == ltf_pkg::SYNC_WORD;
    endproperty
    a_sync: assert property (p_sync) else $error("sync word missing");

    property p_ones;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        running_out |-> &word[77:66];
    endproperty
    a_ones: assert property (p_ones) else $error("sync run of ones broken");

    property p_time_digits;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        word_start_out |-> word[3:0] == time_out.frm_u && word[19:16] == time_out.sec_u
        && word[35:32] == time_out.min_u && word[51:48] == time_out.hr_u;
    endproperty
    a_time_digits: assert property (p_time_digits) else $error("time digits misplaced");

    property p_user;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        word_start_out |-> word[7:4] == $past(user_bits_in[3:0])
        && word[63:60] == $past(user_bits_in[31:28]);
    endproperty
    a_user: assert property (p_user) else $error("user groups altered");

    property p_step_once;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        step |=> !step [*8];
    endproperty
    a_step_once: assert property (p_step_once) else $error("time stepped twice");

    property p_start;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        !running_out && run_in |=> word_start_out && running_out;
    endproperty
    a_start: assert property (p_start) else $error("word did not start on run");

    property p_idle_quiet;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        !running_out && !run_in |=> !word_start_out && !running_out;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("word started while stopped");

    property p_line_still;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        !running_out |=> $stable(longitudinal_code_out);
    endproperty
    a_line_still: assert property (p_line_still) else $error("line moved while idle");

    property p_skip_flag;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        word_start_out
        |-> word[10] == ($past(fmt_in) == ltf_pkg::FMT_30_SKIP || time_out.frm_t[2]);
    endproperty
    a_skip_flag: assert property (p_skip_flag) else $error("skip flag wrong for format");

endmodule

// File: verif/ltf_reader_model.sv
// Behavioural time code reader that decodes the biphase line into words
`timescale 1ns/1ps
module ltf_reader_model
(
    input  wire logic        clk_sys_in,
    input  wire logic        rst_n_in,
    input  wire logic        line_in,
    input  wire logic [7:0]  half_div_in,
    output logic      [79:0] word_out,
    output logic      [15:0] words_out,
    output logic      [15:0] faults_out,
    output logic             reverse_out
);
    logic        last_line;
    logic        half_seen;
    logic [79:0] shreg;
    int          gap;

    ////////////////////////////////////////////////////////////////////////////////
    // One decoded bit; first bit sent ends up in bit 0
    task automatic take_bit(input logic b);
        shreg = {b, shreg[79:1]};
        if (shreg[79:64] == ltf_pkg::SYNC_WORD)
        begin
            word_out  = shreg;
            words_out = words_out + 16'h0001;
        end
        if (shreg[79:64] == 16'h3ffd)
            reverse_out = 1'b1;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Gap between transitions: one half cell or a whole cell
    always @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            last_line   = 1'b0;
            half_seen   = 1'b0;
            shreg       = '0;
            gap         = 32'h0001_0000;
            word_out    = '0;
            words_out   = '0;
            faults_out  = '0;
            reverse_out = 1'b0;
        end
        else
        begin
            gap = gap + 1;
            if (line_in !== last_line)
            begin
                if (gap > 4 * half_div_in)
                    half_seen = 1'b0;
                else if (gap == 2 * half_div_in)
                begin
                    if (half_seen)
                        faults_out = faults_out + 16'h0001;
                    half_seen = 1'b0;
                    take_bit(1'b0);
                end
                else if (gap == half_div_in)
                begin
                    if (half_seen)
                        take_bit(1'b1);
                    half_seen = !half_seen;
                end
                else
                    faults_out = faults_out + 16'h0001;
                gap = 0;
            end
            last_line = line_in;
        end
    end
endmodule

// File: verif/ltf_framer_bench.sv
// Self-checking bench for the time code framer
`timescale 1ns/1ps
module ltf_framer_bench;
    logic                clk_sys_in;
    logic                rst_n_in;
    logic                run_in;
    ltf_pkg::ltf_fmt_t   fmt_in;
    logic                load_in;
    ltf_pkg::ltf_time_t  preset_in;
    logic [31:0]         user_bits_in;
    logic                longitudinal_code_out;
    ltf_pkg::ltf_time_t  time_out;
    logic                word_start_out;
    logic                running_out;
    logic [7:0]          cur_div;
    logic [79:0]         rd_word;
    logic [15:0]         rd_count;
    logic [15:0]         rd_faults;
    logic                rd_reverse;
    int                  miscompares;
    int                  total_checks;
    int                  cycles;

    ltf_framer #(.HALF_DIV_24(6), .HALF_DIV_25(5), .HALF_DIV_30(4)) i_ltf_framer
    (
        .clk_sys_in            (clk_sys_in),
        .rst_n_in              (rst_n_in),
        .run_in                (run_in),
        .fmt_in                (fmt_in),
        .load_in               (load_in),
        .preset_in             (preset_in),
        .user_bits_in          (user_bits_in),
        .longitudinal_code_out (longitudinal_code_out),
        .time_out              (time_out),
        .word_start_out        (word_start_out),
        .running_out           (running_out)
    );

    ltf_reader_model i_ltf_reader_model
    (
        .clk_sys_in  (clk_sys_in),
        .rst_n_in    (rst_n_in),
        .line_in     (longitudinal_code_out),
        .half_div_in (cur_div),
        .word_out    (rd_word),
        .words_out   (rd_count),
        .faults_out  (rd_faults),
        .reverse_out (rd_reverse)
    );

    always #12.5 clk_sys_in = ~clk_sys_in;

    ////////////////////////////////////////////////////////////////////////////////
    // Hang guard
    always @(posedge clk_sys_in)
    begin
        cycles = cycles + 1;
        if (cycles >= 40000)
        begin
            miscompares = miscompares + 1;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checks=%0d miscompares=%0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic check(input logic [79:0] seen, input logic [79:0] exp);
        total_checks = total_checks + 1;
        if (seen !== exp)
        begin
            miscompares = miscompares + 1;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tick();
        @(posedge clk_sys_in);
        #2;
    endtask

    // Word as a reader should see it, bit 0 sent first
    function automatic logic [79:0] exp_word(input logic [31:0] t, input logic [31:0] ub,
                                             input logic skip);
        logic [79:0] w;
        w = '0;
        for (int i = 0; i < 8; i++)
        begin
            w[8*i +: 4]   = t[4*i +: 4];
            w[8*i+4 +: 4] = ub[4*i +: 4];
        end
        w[10]     = w[10] | skip;
        w[79:64]  = ltf_pkg::SYNC_WORD;
        return w;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Loads a time while idle, runs two words, checks step and line content
    task automatic run_case(input ltf_pkg::ltf_fmt_t f, input int d, input logic [31:0] pre,
                            input logic [31:0] ub, input logic [31:0] nxt);
        int          n;
        int          starts;
        logic [15:0] seen;
        fmt_in       = f;
        cur_div      = d[7:0];
        preset_in    = pre;
        user_bits_in = ub;
        load_in      = 1'b1;
        tick();
        load_in = 1'b0;
        run_in  = 1'b1;
        n = 0;
        while (word_start_out !== 1'b1 && n < 20)
        begin
            tick();
            n++;
        end
        check(time_out, pre);
        check(running_out, 1'b1);
        n = 0;
        do
        begin
            tick();
            n++;
        end while (word_start_out !== 1'b1 && n < 2000);
        run_in = 1'b0;
        // First word completes at the cell-start transition of the next word's first bit
        seen = rd_count;
        check(80'(n), 80'(160 * d));
        check(time_out, nxt);
        n = 0;
        while (rd_count == seen && n < 4 * d)
        begin
            tick();
            n++;
        end
        check(rd_word, exp_word(pre, ub, f == ltf_pkg::FMT_30_SKIP));
        while (running_out !== 1'b0 && n < 2000)
        begin
            tick();
            n++;
        end
        check(n >= 160 * d - 2 && n <= 160 * d + 2, 1'b1);
        starts = 0;
        repeat (40)
        begin
            tick();
            starts += int'(word_start_out === 1'b1);
        end
        check(80'(starts), 80'(0));
        check(rd_faults, 16'h0000);
        check(rd_reverse, 1'b0);
    endtask

    task automatic t_reset_state();
        check({longitudinal_code_out, time_out, word_start_out, running_out}, '0);
    endtask

    task automatic t_sec_carry();
        run_case(ltf_pkg::FMT_25, 5, 32'h0000_5924, 32'h8765_4321, 32'h0001_0000);
    endtask

    task automatic t_hour_wrap();
        run_case(ltf_pkg::FMT_30, 4, 32'h2359_5929, 32'h0f1e_2d3c, 32'h0000_0000);
    endtask

    task automatic t_skip_minute();
        run_case(ltf_pkg::FMT_30_SKIP, 4, 32'h0000_5929, 32'h5a5a_a5a5, 32'h0001_0002);
    endtask

    task automatic t_skip_tenth();
        run_case(ltf_pkg::FMT_30_SKIP, 4, 32'h0009_5929, 32'h1234_5678, 32'h0010_0000);
    endtask

    task automatic t_film_rate();
        run_case(ltf_pkg::FMT_24, 6, 32'h1200_0023, 32'hcafe_0123, 32'h1200_0100);
    endtask

    task automatic t_full_frame();
        run_case(ltf_pkg::FMT_30, 4, 32'h0100_5929, 32'h9999_0000, 32'h0101_0000);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk_sys_in   = 1'b0;
        rst_n_in     = 1'b0;
        run_in       = 1'b0;
        fmt_in       = ltf_pkg::FMT_25;
        load_in      = 1'b0;
        preset_in    = '0;
        user_bits_in = '0;
        cur_div      = 8'h05;
        miscompares  = 0;
        total_checks = 0;
        cycles       = 0;
        repeat (8) @(posedge clk_sys_in);
        #2;
        rst_n_in = 1'b1;
        tick();
        t_reset_state();
        t_sec_carry();
        t_hour_wrap();
        t_skip_minute();
        t_skip_tenth();
        t_film_rate();
        t_full_frame();
        give_verdict();
    end
endmodule
